/* rtl/isd_dispatcher.sv */
// Interrupt scan dispatcher: image checker, cyclic timers and input interrupt arbitration.
// Behaviour
// R01: Run each cyclic handler at its period.
// R02: Input handlers only on inputs 1,3,5,7,9.
// R03: Input assertion in run starts its handler.
// R04: Lower input number wins among inputs.
// R05: Entry enabling condition is ignored.
// R06: Input return resumes interrupted program.
// R07: Supplier pairs every input entry with return.
// R08: Supplier declares each input number once.
// R09: Reject duplicate or undefined input handlers.
// R10: Supplier puts condition on cyclic return.
// R11: Reject missing, misplaced, bad-condition cyclic return.
// R12: Each cyclic handler has own millisecond period.
// R13: Shorter cyclic period has higher priority.
// R14: Busy-time arrivals stay pending until return.
`timescale 1ns/1ps

module isd_dispatcher #(
   parameter int unsigned TICK_CYCLES = isd_pkg::TICK_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic               run,
   input  wire logic               load_req,
   input  wire isd_pkg::isd_image_s image,
   input  wire logic               irq_input_one,
   input  wire logic               irq_input_three,
   input  wire logic               irq_input_five,
   input  wire logic               irq_input_seven,
   input  wire logic               irq_input_nine,
   input  wire logic               cyclic_handler_return,
   input  wire logic               input_handler_return,
   output logic                    load_done,
   output logic                    load_ok,
   output logic [3:0]              load_err,
   output logic                    handler_start,
   output logic [3:0]              handler_id,
   output logic                    handler_busy,
   output logic                    resume
);

   localparam int unsigned NC = isd_pkg::NUM_CYC;
   localparam int unsigned NI = isd_pkg::NUM_INP;
   localparam int unsigned NS = isd_pkg::NUM_INP_SLOTS;
   // Maps an input handler number to its terminal index; returns NI when the number is not a legal terminal.
   function automatic logic [2:0] inp_index(input logic [3:0] num);
      case (num)
         4'h1:    inp_index = 3'h0;
         4'h3:    inp_index = 3'h1;
         4'h5:    inp_index = 3'h2;
         4'h7:    inp_index = 3'h3;
         4'h9:    inp_index = 3'h4;
         default: inp_index = 3'h5;
      endcase
   endfunction
   // Image checker state.
   logic            load_done_q, load_done_d;
   logic            load_ok_q,   load_ok_d;
   logic [3:0]      load_err_q,  load_err_d;
   logic [NC-1:0]   cyc_en_q,    cyc_en_d;
   logic [NI-1:0]   inp_en_q,    inp_en_d;
   logic [15:0]     per_q [NC],  per_d [NC];
   logic [3:0]      chk_err;
   logic [NC-1:0]   chk_cyc_en;
   logic [NI-1:0]   chk_inp_en;
   logic [2:0]      idx;
   always_comb begin
      chk_err    = isd_pkg::ERR_NONE;
      chk_cyc_en = '0;
      chk_inp_en = '0;
      idx        = 3'h0;
      for (int s = 0; s < NS; s++) begin
         if (image.inp[s].declared) begin
            idx = inp_index(image.inp[s].number);
            if (idx == 3'h5) begin
               chk_err = isd_pkg::ERR_INP_UNDEF; // [R02] [R09]
            end else if (chk_inp_en[idx]) begin
               chk_err = isd_pkg::ERR_INP_DUP; // [R09]
            end else if (!image.inp[s].ret_present) begin
               chk_err = isd_pkg::ERR_INP_RET;
            end else begin
               chk_inp_en[idx] = 1'b1;
            end
         end
      end
      for (int c = 0; c < NC; c++) begin
         if (image.cyc[c].declared) begin
            if (image.cyc[c].period_ms < isd_pkg::PERIOD_MIN || image.cyc[c].period_ms > isd_pkg::PERIOD_MAX) begin
               chk_err = isd_pkg::ERR_CYC_UNDEF;
            end else if (!image.cyc[c].ret_present) begin
               chk_err = isd_pkg::ERR_RET_MISSING; // [R11]
            end else if (!image.cyc[c].ret_area_ok) begin
               chk_err = isd_pkg::ERR_RET_AREA; // [R11]
            end else if (!image.cyc[c].ret_cond_ok) begin
               chk_err = isd_pkg::ERR_RET_COND; // [R11]
            end
            for (int o = 0; o < c; o++) begin
               if (image.cyc[o].declared && image.cyc[o].period_ms == image.cyc[c].period_ms) begin
                  chk_err = isd_pkg::ERR_CYC_DUP;
               end
            end
            chk_cyc_en[c] = 1'b1;
         end
      end
   end

   always_comb begin
      load_done_d = 1'b0;
      load_ok_d   = load_ok_q;
      load_err_d  = load_err_q;
      cyc_en_d    = cyc_en_q;
      inp_en_d    = inp_en_q;
      per_d       = per_q;
      if (load_req) begin
         load_done_d = 1'b1;
         if (run) begin
            load_ok_d  = 1'b0;
            load_err_d = isd_pkg::ERR_BUSY;
         end else if (chk_err != isd_pkg::ERR_NONE) begin
            // A rejected image never replaces the running configuration.
            load_ok_d  = 1'b0;
            load_err_d = chk_err; // [R09] [R11]
         end else begin
            load_ok_d  = 1'b1;
            load_err_d = isd_pkg::ERR_NONE;
            cyc_en_d   = chk_cyc_en;
            inp_en_d   = chk_inp_en;
            for (int c = 0; c < NC; c++) begin
               per_d[c] = image.cyc[c].period_ms; // [R12]
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         load_done_q <= 1'b0;
         load_ok_q   <= 1'b0;
         load_err_q  <= isd_pkg::ERR_NONE;
         cyc_en_q    <= '0;
         inp_en_q    <= '0;
         per_q       <= '{default: isd_pkg::RST_PERIOD};
      end else begin
         load_done_q <= load_done_d;
         load_ok_q   <= load_ok_d;
         load_err_q  <= load_err_d;
         cyc_en_q    <= cyc_en_d;
         inp_en_q    <= inp_en_d;
         per_q       <= per_d;
      end
   end

   // Millisecond timebase, cyclic counters and pending flags.
   logic [$clog2(TICK_CYCLES)-1:0] div_q, div_d;
   logic                           tick;
   logic [15:0]                    cnt_q [NC],  cnt_d [NC];
   logic [NC-1:0]                  cpend_q, cpend_d;
   logic [NI-1:0]                  ipend_q, ipend_d;
   logic [NI-1:0]                  irq_prev_q;
   logic [NI-1:0]                  irq_v;
   logic [NC-1:0]                  cyc_fire;
   logic [NC-1:0]                  cyc_take;
   logic [NI-1:0]                  inp_take;
   assign irq_v = {irq_input_nine, irq_input_seven, irq_input_five, irq_input_three, irq_input_one};
   assign tick  = (div_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
   always_comb begin
      div_d    = run ? (tick ? '0 : div_q + 1'b1) : '0;
      cnt_d    = cnt_q;
      cyc_fire = '0;
      for (int c = 0; c < NC; c++) begin
         if (!run || !cyc_en_q[c]) begin
            cnt_d[c] = isd_pkg::RST_COUNT;
         end else if (tick && cnt_q[c] == per_q[c] - 16'h0001) begin
            cnt_d[c]    = isd_pkg::RST_COUNT;
            cyc_fire[c] = 1'b1; // [R01] [R12]
         end else if (tick) begin
            cnt_d[c] = cnt_q[c] + 16'h0001;
         end
      end
      // A new event in the cycle its flag is taken keeps the flag set.
      cpend_d = run ? ((cpend_q & ~cyc_take) | cyc_fire) : '0; // [R14]
      // Only the rising edge matters; any entry condition in the image is never consulted.
      ipend_d = run ? ((ipend_q & ~inp_take) | (irq_v & ~irq_prev_q & inp_en_q)) : '0; // [R03] [R05] [R14]
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_q      <= '0;
         cpend_q    <= '0;
         ipend_q    <= '0;
         irq_prev_q <= '0;
         cnt_q      <= '{default: isd_pkg::RST_COUNT};
      end else begin
         div_q      <= div_d;
         cpend_q    <= cpend_d;
         ipend_q    <= ipend_d;
         irq_prev_q <= irq_v;
         cnt_q      <= cnt_d;
      end
   end

   // Dispatch: one handler at a time, no preemption, inputs ahead of cyclic handlers.
   isd_pkg::isd_state_e state_q, state_d;
   logic                start_q, start_d;
   logic [3:0]          id_q,    id_d;
   logic                resume_q, resume_d;
   logic                ret_ok;
   logic [15:0]         best_per;
   logic [NC-1:0]       cyc_sel;
   logic [NI-1:0]       inp_sel;
   always_comb begin
      inp_sel  = '0;
      cyc_sel  = '0;
      best_per = 16'hffff;
      for (int i = NI - 1; i >= 0; i--) begin
         if (ipend_q[i]) begin
            inp_sel = '0;
            inp_sel[i] = 1'b1; // [R04]
         end
      end
      for (int c = 0; c < NC; c++) begin
         if (cpend_q[c] && per_q[c] <= best_per) begin
            best_per = per_q[c];
            cyc_sel  = '0;
            cyc_sel[c] = 1'b1; // [R13]
         end
      end
   end
   // A return only counts when it matches the kind of handler now running.
   assign ret_ok = (id_q < isd_pkg::ID_INP_BASE) ? cyclic_handler_return : input_handler_return;
   always_comb begin
      state_d  = state_q;
      start_d  = 1'b0;
      id_d     = id_q;
      resume_d = 1'b0;
      cyc_take = '0;
      inp_take = '0;
      case (state_q)
         isd_pkg::ISD_IDLE: begin
            if (run && ipend_q != '0) begin
               inp_take = inp_sel;
               start_d  = 1'b1;
               state_d  = isd_pkg::ISD_RUNNING;
               for (int i = 0; i < NI; i++) begin
                  if (inp_sel[i]) begin
                     id_d = isd_pkg::ID_INP_BASE + 4'(i); // [R03]
                  end
               end
            end else if (run && cpend_q != '0) begin
               cyc_take = cyc_sel;
               start_d  = 1'b1;
               state_d  = isd_pkg::ISD_RUNNING;
               for (int c = 0; c < NC; c++) begin
                  if (cyc_sel[c]) begin
                     id_d = isd_pkg::ID_CYC_BASE + 4'(c); // [R01]
                  end
               end
            end
         end
         isd_pkg::ISD_RUNNING: begin
            // Dropping run abandons the handler, so no resume is signalled for it.
            if (!run || ret_ok) begin
               resume_d = run; // [R06]
               state_d  = isd_pkg::ISD_IDLE;
               id_d     = isd_pkg::ID_NONE;
            end
         end
         default: begin
            state_d = isd_pkg::ISD_IDLE;
            id_d    = isd_pkg::ID_NONE;
         end
      endcase
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q  <= isd_pkg::ISD_IDLE;
         start_q  <= 1'b0;
         id_q     <= isd_pkg::ID_NONE;
         resume_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         start_q  <= start_d;
         id_q     <= id_d;
         resume_q <= resume_d;
      end
   end
   assign load_done     = load_done_q;
   assign load_ok       = load_ok_q;
   assign load_err      = load_err_q;
   assign handler_start = start_q;
   assign handler_id    = id_q;
   assign handler_busy  = (state_q == isd_pkg::ISD_RUNNING);
   assign resume        = resume_q;
endmodule

/* inc/isd_pkg.sv */
// Shared constants and carrier types for the interrupt scan dispatcher.
package isd_pkg;

   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned TICK_MS       = 1;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

   localparam int unsigned NUM_CYC       = 4;
   localparam int unsigned NUM_INP       = 5;
   localparam int unsigned NUM_INP_SLOTS = 4;
   localparam logic [15:0] PERIOD_MIN    = 16'h0005;
   localparam logic [15:0] PERIOD_MAX    = 16'hea60;

   // Handler ids: cyclic slots first, then input terminals one, three, five, seven, nine.
   localparam logic [3:0]  ID_CYC_BASE   = 4'h0;
   localparam logic [3:0]  ID_INP_BASE   = 4'h4;
   localparam logic [3:0]  ID_NONE       = 4'hf;

   localparam logic [3:0]  ERR_NONE          = 4'h0;
   localparam logic [3:0]  ERR_INP_DUP       = 4'h1;
   localparam logic [3:0]  ERR_INP_UNDEF     = 4'h2;
   localparam logic [3:0]  ERR_CYC_DUP       = 4'h3;
   localparam logic [3:0]  ERR_CYC_UNDEF     = 4'h4;
   localparam logic [3:0]  ERR_RET_MISSING   = 4'h5;
   localparam logic [3:0]  ERR_RET_AREA      = 4'h6;
   localparam logic [3:0]  ERR_RET_COND      = 4'h7;
   localparam logic [3:0]  ERR_INP_RET       = 4'h8;
   localparam logic [3:0]  ERR_BUSY          = 4'h9;

   localparam logic [15:0] RST_PERIOD    = 16'h0000;
   localparam logic [15:0] RST_COUNT     = 16'h0000;

   typedef struct packed {
      logic        declared;
      logic [15:0] period_ms;
      logic        ret_present;
      logic        ret_area_ok;
      logic        ret_cond_ok;
   } isd_cyc_cfg_s;

   typedef struct packed {
      logic        declared;
      logic [3:0]  number;
      logic        entry_cond;
      logic        ret_present;
   } isd_inp_cfg_s;

   typedef struct packed {
      isd_cyc_cfg_s [NUM_CYC-1:0]       cyc;
      isd_inp_cfg_s [NUM_INP_SLOTS-1:0] inp;
   } isd_image_s;

   typedef enum logic [0:0] {
      ISD_IDLE,
      ISD_RUNNING
   } isd_state_e;

endpackage

/* sim/isd_dispatcher_asserts.sv */
// Port-level checks for the interrupt scan dispatcher.
`timescale 1ns/1ps
module isd_asserts #(
   parameter int unsigned TICK_CYCLES = 4
) (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       run,
   input wire logic       load_req,
   input wire logic       cyclic_handler_return,
   input wire logic       input_handler_return,
   input wire logic       load_done,
   input wire logic       load_ok,
   input wire logic [3:0] load_err,
   input wire logic       handler_start,
   input wire logic [3:0] handler_id,
   input wire logic       handler_busy,
   input wire logic       resume
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   load_ans_a: assert property (load_req |=> load_done) else $error("load not answered");
   busy_load_a: assert property (load_req && run |=> !load_ok && load_err == isd_pkg::ERR_BUSY)
      else $error("load in run not refused");
   done_cause_a: assert property (load_done |-> $past(load_req)) else $error("stray load done");
   id_range_a: assert property (handler_id inside {[4'h0:4'h8], 4'hf}) else $error("bad handler id");
   busy_id_a: assert property (handler_busy == (handler_id != isd_pkg::ID_NONE))
      else $error("busy and id disagree");
   idle_run_a: assert property (!run ##1 !run |-> !handler_start) else $error("start outside run");
   no_preempt_a: assert property (handler_start |-> !$past(handler_busy)) else $error("handler preempted");
   hold_id_a: assert property (handler_busy && $past(handler_busy) |-> $stable(handler_id))
      else $error("id changed while busy");
   inp_ret_a: assert property (handler_busy && handler_id inside {[4'h4:4'h8]} && input_handler_return && run
      |=> resume && !handler_busy) else $error("input return not resumed");
   cyc_ret_a: assert property (handler_busy && handler_id inside {[4'h0:4'h3]} && cyclic_handler_return && run
      |=> resume && !handler_busy) else $error("cyclic return not resumed");
   res_cause_a: assert property (resume |-> $past(input_handler_return || cyclic_handler_return))
      else $error("stray resume");

   cover property (handler_start && handler_id == 4'h5);
   cover property (resume);
   cover property (handler_start && handler_id == 4'h1);
   cover property (load_done && !load_ok);
endmodule

bind isd_dispatcher isd_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_isd_asserts (
   .clk(clk), .nrst(nrst), .run(run), .load_req(load_req), .cyclic_handler_return(cyclic_handler_return),
   .input_handler_return(input_handler_return), .load_done(load_done), .load_ok(load_ok), .load_err(load_err),
   .handler_start(handler_start), .handler_id(handler_id), .handler_busy(handler_busy), .resume(resume));

/* sim/isd_dispatcher_tb.sv */
// Self-checking testbench for the interrupt scan dispatcher.
`timescale 1ns/1ps
module isd_dispatcher_tb;
   localparam int TK = 4;
   logic                clk = 0, nrst = 0, run = 0, lreq = 0, cret = 0, iret = 0;
   logic [4:0]          irq = 5'h00;
   isd_pkg::isd_image_s img = '0, m;
   logic                ldone, lok, hstart, hbusy, resume;
   logic [3:0]          lerr, hid;
   int                  failures = 0, n_tests = 0, seed = 92, cyc_n = 0, t0, k, r;

   always #12.5 clk = ~clk;
   always @(posedge clk) cyc_n <= cyc_n + 1;

   isd_dispatcher #(.TICK_CYCLES(TK)) i_isd_dispatcher (
      .clk(clk), .nrst(nrst), .run(run), .load_req(lreq), .image(img),
      .irq_input_one(irq[0]), .irq_input_three(irq[1]), .irq_input_five(irq[2]),
      .irq_input_seven(irq[3]), .irq_input_nine(irq[4]),
      .cyclic_handler_return(cret), .input_handler_return(iret), .load_done(ldone), .load_ok(lok),
      .load_err(lerr), .handler_start(hstart), .handler_id(hid), .handler_busy(hbusy), .resume(resume));

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Entry conditions are set everywhere so that an honoured one would show.
   function automatic isd_pkg::isd_image_s mk(input bit cy, input bit ip);
      isd_pkg::isd_image_s x;
      logic [15:0]         nums;
      nums = 16'h9531;
      x = '0;
      x.cyc[0] = '{cy, 16'h0005, 1'b1, 1'b1, 1'b1};
      x.cyc[1] = '{cy, 16'h000a, 1'b1, 1'b1, 1'b1};
      for (int i = 0; i < 4; i++) x.inp[i] = '{ip, nums[4*i+:4], 1'b1, 1'b1};
      return x;
   endfunction

   function automatic logic [3:0] experr(input int j);
      return (j == 0 || j == 10) ? 4'h0 : (j < 5) ? 4'(j) : 4'(j - 1);
   endfunction

   task automatic load(input isd_pkg::isd_image_s x, input logic [3:0] e);
      @(negedge clk);
      img = x;
      lreq = 1;
      @(negedge clk);
      lreq = 0;
      chk("load_done", ldone, 1);
      chk("load_err", lerr, e);
      chk("load_ok", lok, e == 0);
   endtask

   task automatic wstart(input logic [3:0] e);
      for (k = 0; k < 400 && hstart !== 1'b1; k++) @(negedge clk);
      if (k == 400) begin
         failures++;
         $display("Error handler_start expected 1 seen 0");
         finish_test();
      end
      chk("handler_id", hid, e);
   endtask

   task automatic ret(input bit inp);
      @(negedge clk);
      if (inp) iret = 1;
      else cret = 1;
      @(negedge clk);
      iret = 0;
      cret = 0;
      chk("resume", resume, 1);
      chk("handler_busy", hbusy, 0);
   endtask

   task automatic quiet(input int n);
      repeat (n) begin
         @(negedge clk);
         chk("handler_start", hstart, 0);
      end
   endtask

   initial begin
      repeat (6) @(negedge clk);
      nrst = 1;
      for (int j = 0; j <= 10; j++) begin
         m = mk(1, 1);
         case (j)
            1: m.inp[1].number = 4'h1;
            2: m.inp[2].number = 4'h2;
            3: m.cyc[1].period_ms = 16'h0005;
            4: m.cyc[0].period_ms = 16'h0004;
            5: m.cyc[1].period_ms = 16'hea61;
            6: m.cyc[0].ret_present = 0;
            7: m.cyc[0].ret_area_ok = 0;
            8: m.cyc[0].ret_cond_ok = 0;
            9: m.inp[3].ret_present = 0;
            10: m.cyc[1].period_ms = 16'hea60;
            default: ;
         endcase
         load(m, experr(j));
      end
      run = 1;
      load(mk(0, 1), isd_pkg::ERR_BUSY);
      run = 0;
      load(mk(0, 1), 4'h0);
      m = mk(0, 1);
      m.inp[1].number = 4'h1;
      load(m, 4'h1);
      $display("load tests done");
      run = 1;
      for (int j = 0; j < 8; j++) begin
         r = (j == 0) ? 3 : $unsigned($random(seed)) % 5;
         @(negedge clk);
         irq[r] = 1;
         if (r == 3) quiet(10);
         else begin
            wstart(4'(4 + r));
            repeat ($unsigned($random(seed)) % 4) @(negedge clk);
            ret(1);
         end
         @(negedge clk);
         irq[r] = 0;
      end
      @(negedge clk);
      irq = 5'h12;
      wstart(4'h5);
      ret(1);
      wstart(4'h8);
      ret(1);
      @(negedge clk);
      irq = 5'h04;
      wstart(4'h6);
      @(negedge clk);
      irq[0] = 1;
      cret = 1;
      @(negedge clk);
      cret = 0;
      @(negedge clk);
      chk("resume", resume, 0);
      chk("handler_id", hid, 4'h6);
      ret(1);
      wstart(4'h4);
      ret(1);
      @(negedge clk);
      irq = 5'h00;
      run = 0;
      @(negedge clk);
      irq[0] = 1;
      quiet(12);
      irq[0] = 0;
      $display("input tests done");
      load(mk(1, 0), 4'h0);
      run = 1;
      wstart(4'h0);
      t0 = cyc_n;
      ret(0);
      wstart(4'h0);
      chk("period", 16'(cyc_n - t0), 16'(5 * TK));
      ret(0);
      wstart(4'h1);
      ret(0);
      wstart(4'h0);
      ret(0);
      // Leaving run while a handler is active must drop it without a resume.
      wstart(4'h0);
      @(negedge clk);
      run = 0;
      @(negedge clk);
      chk("handler_busy", hbusy, 0);
      chk("handler_id", hid, 4'hf);
      chk("resume", resume, 0);
      $display("cyclic tests done");
      finish_test();
   end
endmodule
